// ==== hw/csgac_pkg.sv ====
// Purpose: constants for the command source gate and alarm code block
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes: register map sits on an Avalon-MM slave with waitrequest
// What this block does
// R01: without mode selection, all contact and enabled serial commands always pass.
// R02: mode may be chosen from panel, contact input or serial command.
// R03: local mode passes panel commands only, blocking contact and serial ones.
// R04: exempt trips, pickup override, permissive, dynamics, mode and serial trip always pass.
// R05: panel commands always count as local origin.
// R06: local-plus-remote mode passes panel, contact and all serial commands.
// R07: mode contact closed selects local-plus-remote, open selects local.
// R08: optional relay output asserted while local mode is in effect.
// R09: selected mode is readable over the serial status register.
// R10: option lets all contact and serial commands stay active in local mode.
// R11: code 1 first sensor fail, 2 second sensor fail, 0 all cleared.
// R12: analog input failures map to codes 3, 7-9, 28-31, 35, 37.
// R13: code 12 high-pressure actuator fail, 13 low-pressure actuator fail.
// R14: code 14 when start commanded without permissive.
// R15: codes 15 and 16 for serial port one and two errors.
// R16: code 20 overspeed trip, 27 speed stuck in critical band.
// R17: reserved codes never raised; 18 only when shutdown alarm enabled.
// R18: code 32 for speed setpoint ordering error.
// R19: code 33 for steam map point arrangement error.
// R20: code 34 for setpoint entered inside a critical band.
// R21: first alarm code is held and readable.
// R22: first alarm keeps earliest since clear, later ignored, zero on reset.
package csgac_pkg;
  localparam int ADDR_W = 4;
  localparam int NUM_ALARM = 38;
  localparam int CMD_W = 16;
  localparam logic [5:0] CODE_NONE = 6'h00;
  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ALARM = 4'h8;
  localparam logic [ADDR_W-1:0] REG_PANEL = 4'hC;
  // cfg bits
  localparam int CFG_MODE_EN = 0;
  localparam int CFG_SERIAL_EN = 1;
  localparam int CFG_LOCAL_ALL = 2;
  localparam int CFG_MODE_SRC_LO = 3;
  localparam int CFG_RELAY_EN = 5;
  localparam int CFG_SHUT_EN = 6;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  // mode source select
  localparam logic [1:0] SRC_PANEL = 2'h0;
  localparam logic [1:0] SRC_CONTACT = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  // exempt contact positions: trips 0..4, override, permissive, dynamics, mode select
  localparam logic [CMD_W-1:0] CONTACT_EXEMPT = 16'h01FF;
  // exempt serial positions: mode select bit 0, trip bit 1
  localparam logic [CMD_W-1:0] SERIAL_EXEMPT = 16'h0003;
  // alarm cause bit positions equal their codes; reserved codes masked out
  localparam logic [NUM_ALARM-1:0] ALARM_VALID = 38'h2F_F815_F38E;
  localparam int CODE_SHUTDOWN = 18;
  typedef enum logic [1:0] {
    CSGAC_IDLE = 2'b00,
    CSGAC_ACK = 2'b01
  } csgac_bus_type;
endpackage

// ==== hw/csgac_alarm_if.sv ====
`timescale 1ns/1ps
// Purpose: carries alarm causes and first-alarm result
// Assumes: all signals synchronous to ref_clk
// Notes: shared between top and first-alarm encoder
interface csgac_alarm_if;
  import csgac_pkg::*;
  logic [NUM_ALARM-1:0] cause;
  logic clear;
  logic [5:0] first_code;
  logic any;
  modport src (output cause, output clear, input first_code, input any);
  modport enc (input cause, input clear, output first_code, output any);
endinterface

// ==== hw/csgac_first_alarm.sv ====
`timescale 1ns/1ps
// Purpose: priority encode alarm causes and latch the first one
// Assumes: causes are levels; clear is a one-cycle pulse
// Notes: lowest code wins when several arrive together
module csgac_first_alarm (
  input wire logic ref_clk,
  input wire logic nrst,
  csgac_alarm_if.enc al
);
  import csgac_pkg::*;
  logic [5:0] first_q;
  logic [5:0] first_d;
  logic [5:0] enc_code;
  // lowest set valid bit, zero if none
  function automatic logic [5:0] lowest(input logic [NUM_ALARM-1:0] v);
    logic [5:0] r;
    r = CODE_NONE;
    for (int i = NUM_ALARM - 1; i > 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction
  assign enc_code = lowest(al.cause & ALARM_VALID); // R17
  // new alarm in clear cycle still latches, set wins
  assign first_d = (first_q == CODE_NONE) ? enc_code :
                   (al.clear ? enc_code : first_q); // R22
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      first_q <= CODE_NONE;
    end else begin
      first_q <= first_d; // R21
    end
  end
  assign al.first_code = first_q;
  assign al.any = (first_q != CODE_NONE);
endmodule

// ==== hw/csgac_top.sv ====
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
// Purpose: gate commands by source and mode, and encode alarm causes
// Assumes: inputs synchronous to ref_clk; Avalon-MM master holds requests
// Notes: register reads answer one cycle after the request
module csgac_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [csgac_pkg::CMD_W-1:0] panel_cmd,
  input wire logic [csgac_pkg::CMD_W-1:0] contact_cmd,
  input wire logic [csgac_pkg::CMD_W-1:0] serial_cmd,
  input wire logic mode_contact,
  input wire logic serial_mode_sel,
  input wire logic serial_mode_val,
  output logic [csgac_pkg::CMD_W-1:0] panel_cmd_out,
  output logic [csgac_pkg::CMD_W-1:0] contact_cmd_out,
  output logic [csgac_pkg::CMD_W-1:0] serial_cmd_out,
  output logic local_relay,
  input wire logic speed_sense1_fail,
  input wire logic speed_sense2_fail,
  input wire logic [10:0] analog_fail,
  input wire logic hp_act_fail,
  input wire logic lp_act_fail,
  input wire logic start_cmd,
  input wire logic start_permissive,
  input wire logic serial1_err,
  input wire logic serial2_err,
  input wire logic shutdown_alarm,
  input wire logic overspeed_trip,
  input wire logic speed_stuck,
  input wire logic speed_cfg_err,
  input wire logic steam_map_err,
  input wire logic setpoint_in_band,
  input wire logic alarm_reset,
  output logic [5:0] first_alarm
);
  import csgac_pkg::*;
  logic [CFG_W-1:0] cfg_q;
  logic [CFG_W-1:0] cfg_d;
  logic remote_q;
  logic remote_d;
  logic panel_mode_wr;
  logic [CMD_W-1:0] panel_cmd_q;
  logic [CMD_W-1:0] contact_cmd_q;
  logic [CMD_W-1:0] serial_cmd_q;
  logic [CMD_W-1:0] contact_mask;
  logic [CMD_W-1:0] serial_mask;
  logic local_relay_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [NUM_ALARM-1:0] cause;
  logic open_all;
  logic local_mode;
  logic [1:0] mode_src;
  logic sw_clear;
  csgac_bus_type bus_q;
  csgac_bus_type bus_d;
  csgac_alarm_if al ();

  // bus handshake: one wait cycle, then ack
  logic req;
  logic wr_hit;
  assign req = avs_read | avs_write;
  assign bus_d = (bus_q == CSGAC_IDLE && req) ? CSGAC_ACK : CSGAC_IDLE;
  assign avs_waitrequest = req & (bus_q != CSGAC_ACK);
  assign wr_hit = avs_write & (bus_q == CSGAC_ACK);
  assign avs_readdata = rdata_q;

  // config write, low byte lane only
  assign cfg_d = (wr_hit && avs_address == REG_CFG && avs_byteenable[0]) ?
                 avs_writedata[CFG_W-1:0] : cfg_q;
  assign mode_src = cfg_q[CFG_MODE_SRC_LO +: 2];
  // panel mode request: write panel register bit 0
  assign panel_mode_wr = wr_hit && avs_address == REG_PANEL && avs_byteenable[0];
  // software alarm reset via alarm register write
  assign sw_clear = wr_hit && avs_address == REG_ALARM;

  // mode selection from the configured source
  always_comb begin
    remote_d = remote_q;
    if (cfg_q[CFG_MODE_EN]) begin // R02
      case (mode_src)
        SRC_PANEL: begin
          if (panel_mode_wr) begin
            remote_d = avs_writedata[0]; // R05
          end
        end
        SRC_CONTACT: begin
          remote_d = mode_contact; // R07
        end
        SRC_SERIAL: begin
          if (serial_mode_sel && cfg_q[CFG_SERIAL_EN]) begin
            remote_d = serial_mode_val;
          end
        end
        default: begin
          remote_d = remote_q;
        end
      endcase
    end
  end

  // gating: remote mode, disabled function or the option open all contact commands, and all serial ones when serial is enabled
  assign local_mode = cfg_q[CFG_MODE_EN] & ~remote_q;
  assign open_all = ~local_mode | cfg_q[CFG_LOCAL_ALL]; // R01 R06 R10
  assign contact_mask = open_all ? {CMD_W{1'b1}} : CONTACT_EXEMPT; // R03 R04
  assign serial_mask = ~cfg_q[CFG_SERIAL_EN] ? {CMD_W{1'b0}} :
                       (open_all ? {CMD_W{1'b1}} : SERIAL_EXEMPT); // R03 R04

  // alarm causes, bit index is the code
  always_comb begin
    cause = '0;
    cause[1] = speed_sense1_fail; // R11
    cause[2] = speed_sense2_fail; // R11
    cause[3] = analog_fail[0]; // R12
    cause[9:7] = analog_fail[3:1]; // R12
    cause[12] = hp_act_fail; // R13
    cause[13] = lp_act_fail; // R13
    cause[14] = start_cmd & ~start_permissive; // R14
    cause[15] = serial1_err; // R15
    cause[16] = serial2_err; // R15
    cause[CODE_SHUTDOWN] = shutdown_alarm & cfg_q[CFG_SHUT_EN]; // R17
    cause[20] = overspeed_trip; // R16
    cause[27] = speed_stuck; // R16
    cause[31:28] = analog_fail[7:4]; // R12
    cause[32] = speed_cfg_err; // R18
    cause[33] = steam_map_err; // R19
    cause[34] = setpoint_in_band; // R20
    cause[35] = analog_fail[8]; // R12
    cause[37] = analog_fail[9]; // R12
  end
  assign al.cause = cause;
  assign al.clear = alarm_reset | sw_clear;

  csgac_first_alarm u_first (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .al(al)
  );
  assign first_alarm = al.first_code; // R21

  // read mux
  always_comb begin
    rdata_d = rdata_q;
    if (avs_read && bus_q == CSGAC_IDLE) begin
      case (avs_address)
        REG_CFG: rdata_d = {25'h0, cfg_q};
        REG_STAT: rdata_d = {29'h0, cfg_q[CFG_MODE_EN], local_mode, remote_q}; // R09
        REG_ALARM: rdata_d = {25'h0, al.any, al.first_code}; // R21
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // registers and gated command outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_q <= CFG_RESET;
      remote_q <= 1'b0;
      bus_q <= CSGAC_IDLE;
      rdata_q <= 32'h0000_0000;
      panel_cmd_q <= '0;
      contact_cmd_q <= '0;
      serial_cmd_q <= '0;
      local_relay_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      remote_q <= remote_d;
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      panel_cmd_q <= panel_cmd; // R05
      contact_cmd_q <= contact_cmd & contact_mask; // R03
      serial_cmd_q <= serial_cmd & serial_mask; // R06
      local_relay_q <= local_mode & cfg_q[CFG_RELAY_EN]; // R08
    end
  end
  assign panel_cmd_out = panel_cmd_q;
  assign contact_cmd_out = contact_cmd_q;
  assign serial_cmd_out = serial_cmd_q;
  assign local_relay = local_relay_q;
endmodule

// ==== dv/csgac_chk.sv ====
// Purpose: port-level checks for the command gate and alarm encoder
// Assumes: one clock, synchronous active-low reset
// Notes: attached to the top by the bind at the foot
`timescale 1ns/1ps
module csgac_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [csgac_pkg::CMD_W-1:0] panel_cmd,
  input wire logic [csgac_pkg::CMD_W-1:0] contact_cmd,
  input wire logic [csgac_pkg::CMD_W-1:0] serial_cmd,
  input wire logic [csgac_pkg::CMD_W-1:0] panel_cmd_out,
  input wire logic [csgac_pkg::CMD_W-1:0] contact_cmd_out,
  input wire logic [csgac_pkg::CMD_W-1:0] serial_cmd_out,
  input wire logic speed_sense1_fail,
  input wire logic alarm_reset,
  input wire logic [5:0] first_alarm
);
  import csgac_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // a new request waits exactly one cycle
  sequence s_wait_then_go;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_BUS_ONE_WAIT: assert property ($rose(avs_read || avs_write) |-> s_wait_then_go)
    else $error("bus answer not after one wait cycle");
  AST_PANEL_PASS: assert property ($past(nrst) |-> panel_cmd_out == $past(panel_cmd))
    else $error("panel command not passed");
  AST_CONTACT_EXEMPT: assert property ($past(nrst) |->
    (contact_cmd_out & CONTACT_EXEMPT) == ($past(contact_cmd) & CONTACT_EXEMPT))
    else $error("exempt contact blocked");
  AST_CONTACT_MASK: assert property ($past(nrst) |-> (contact_cmd_out & ~$past(contact_cmd)) == '0)
    else $error("contact output without input");
  AST_SERIAL_MASK: assert property ($past(nrst) |-> (serial_cmd_out & ~$past(serial_cmd)) == '0)
    else $error("serial output without input");
  AST_FIRST_HOLD: assert property (first_alarm != CODE_NONE && !alarm_reset && !avs_write
    |=> $stable(first_alarm)) else $error("first alarm changed");
  AST_FIRST_SENSOR: assert property (first_alarm == CODE_NONE && speed_sense1_fail && !avs_write
    |=> first_alarm == 6'h01) else $error("sensor one code missing");
  AST_NO_RESERVED: assert property (first_alarm <= 6'h25 && !(first_alarm inside
    {[6'h04:6'h06], 6'h0A, 6'h0B, 6'h11, 6'h13, [6'h15:6'h1A], 6'h24}))
    else $error("reserved alarm code");
endmodule
bind csgac_top csgac_chk csgac_chk_i (.ref_clk, .nrst, .avs_read, .avs_write, .avs_waitrequest,
  .panel_cmd, .contact_cmd, .serial_cmd, .panel_cmd_out, .contact_cmd_out, .serial_cmd_out,
  .speed_sense1_fail, .alarm_reset, .first_alarm);

// ==== dv/csgac_far.sv ====
// Purpose: far-side model of panel, contact and serial command sources
// Assumes: words change just after the rising edge
// Notes: rolls a pattern unless hold asks for all-ones words
`timescale 1ns/1ps
module csgac_far (
  input wire logic ref_clk,
  input wire logic hold,
  output logic [csgac_pkg::CMD_W-1:0] panel_cmd,
  output logic [csgac_pkg::CMD_W-1:0] contact_cmd,
  output logic [csgac_pkg::CMD_W-1:0] serial_cmd
);
  import csgac_pkg::*;
  logic [CMD_W-1:0] pat_q = 16'h0001;
  logic hold_q = 1'b1;
  // moving words so the mask checks see every bit toggle
  always @(posedge ref_clk) begin
    pat_q <= pat_q + 16'h3A5B;
    hold_q <= hold;
  end
  // all-ones makes the gate mask directly visible
  assign panel_cmd = hold_q ? 16'hFFFF : pat_q;
  assign contact_cmd = hold_q ? 16'hFFFF : ~pat_q;
  assign serial_cmd = hold_q ? 16'hFFFF : {pat_q[7:0], pat_q[15:8]};
endmodule

// ==== dv/tb.sv ====
// Purpose: register-driven test of command gating and alarm codes
// Assumes: one wait cycle per bus access, outputs one cycle after inputs
// Notes: alarm causes come from one vector, one bit per code
`timescale 1ns/1ps
module tb;
  import csgac_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, hold = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, local_relay, mode_contact = 1'b0, alarm_reset = 1'b0;
  logic serial_mode_sel = 1'b0, serial_mode_val = 1'b0, start_permissive = 1'b0;
  logic [CMD_W-1:0] panel_cmd, contact_cmd, serial_cmd, panel_cmd_out, contact_cmd_out;
  logic [CMD_W-1:0] serial_cmd_out;
  logic [22:0] al = '0;
  logic [5:0] first_alarm;
  int fails = 0, checks = 0;
  localparam logic [5:0] CODES [23] = '{6'h01, 6'h02, 6'h03, 6'h07, 6'h08, 6'h09, 6'h1C, 6'h1D,
    6'h1E, 6'h1F, 6'h23, 6'h25, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h12, 6'h14, 6'h1B, 6'h20,
    6'h21, 6'h22};
  always #12.5 ref_clk = ~ref_clk;
  csgac_top csgac_top_i (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .panel_cmd, .contact_cmd, .serial_cmd,
    .mode_contact, .serial_mode_sel, .serial_mode_val, .panel_cmd_out, .contact_cmd_out,
    .serial_cmd_out, .local_relay, .speed_sense1_fail(al[0]), .speed_sense2_fail(al[1]),
    .analog_fail({1'b0, al[11:2]}), .hp_act_fail(al[12]), .lp_act_fail(al[13]),
    .start_cmd(al[14]), .start_permissive, .serial1_err(al[15]), .serial2_err(al[16]),
    .shutdown_alarm(al[17]), .overspeed_trip(al[18]), .speed_stuck(al[19]),
    .speed_cfg_err(al[20]), .steam_map_err(al[21]), .setpoint_in_band(al[22]), .alarm_reset,
    .first_alarm);
  csgac_far csgac_far_i (.ref_clk, .hold, .panel_cmd, .contact_cmd, .serial_cmd);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // request held until the rising edge that sees waitrequest low, released at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      $display("[FAIL] %0t bus answer timed out", $time);
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic cmds(input logic [15:0] c, input logic [15:0] s);
    settle();
    chk({16'h0, panel_cmd_out}, 32'hFFFF);
    chk({16'h0, contact_cmd_out}, {16'h0, c});
    chk({16'h0, serial_cmd_out}, {16'h0, s});
  endtask
  task automatic smode(input logic v);
    @(posedge ref_clk);
    serial_mode_sel <= 1'b1;
    serial_mode_val <= v;
    @(posedge ref_clk);
    serial_mode_sel <= 1'b0;
  endtask
  task automatic clr;
    @(posedge ref_clk);
    al <= '0;
    alarm_reset <= 1'b1;
    @(posedge ref_clk);
    alarm_reset <= 1'b0;
    settle();
  endtask
  // gating by mode and source, then one alarm code at a time
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(REG_CFG, 32'h0);
    rd(4'h2, 32'h0);
    cmds(16'hFFFF, 16'h0000);
    bus(1'b1, REG_CFG, 32'h02);
    cmds(16'hFFFF, 16'hFFFF);
    bus(1'b1, REG_CFG, 32'h03);
    cmds(16'h01FF, 16'h0003);
    rd(REG_STAT, 32'h6);
    chk({31'h0, local_relay}, 32'h0);
    bus(1'b1, REG_CFG, 32'h23);
    settle();
    chk({31'h0, local_relay}, 32'h1);
    bus(1'b1, REG_PANEL, 32'h1);
    cmds(16'hFFFF, 16'hFFFF);
    rd(REG_STAT, 32'h5);
    chk({31'h0, local_relay}, 32'h0);
    bus(1'b1, REG_CFG, 32'h2B);
    cmds(16'h01FF, 16'h0003);
    @(posedge ref_clk);
    mode_contact <= 1'b1;
    cmds(16'hFFFF, 16'hFFFF);
    bus(1'b1, REG_CFG, 32'h33);
    smode(1'b0);
    cmds(16'h01FF, 16'h0003);
    smode(1'b1);
    cmds(16'hFFFF, 16'hFFFF);
    smode(1'b0);
    bus(1'b1, REG_CFG, 32'h37);
    rd(REG_STAT, 32'h6);
    cmds(16'hFFFF, 16'hFFFF);
    @(posedge ref_clk);
    hold <= 1'b0;
    bus(1'b1, REG_CFG, 32'h00);
    al[17] <= 1'b1;
    settle();
    chk({26'h0, first_alarm}, 32'h0);
    bus(1'b1, REG_CFG, 32'h40);
    settle();
    chk({26'h0, first_alarm}, 32'h12);
    clr();
    for (int i = 0; i < 23; i++) begin
      @(posedge ref_clk);
      al <= 23'h1 << i;
      settle();
      chk({26'h0, first_alarm}, {26'h0, CODES[i]});
      clr();
      chk({26'h0, first_alarm}, 32'h0);
    end
    @(posedge ref_clk);
    al <= 23'h1 << 18;
    settle();
    @(posedge ref_clk);
    al <= 23'h40001;
    settle();
    rd(REG_ALARM, 32'h54);
    bus(1'b1, REG_ALARM, 32'h0);
    settle();
    chk({26'h0, first_alarm}, 32'h1);
    clr();
    @(posedge ref_clk);
    start_permissive <= 1'b1;
    al <= 23'h1 << 14;
    settle();
    chk({26'h0, first_alarm}, 32'h0);
    finish_test();
  end
endmodule
